// >>> rtl/fpc_top.sv
// Purpose: Global frame policy registers and per-frame policy decision
// Assumes: Frame descriptors and mirror masks come from logic on sys_clk_in
// Notes: Decided words pass an 8 deep FIFO and a registered output stage
// Overview of operation
// - Size check disabled: frames up to 1536 bytes inclusive are accepted
// - Size check enabled: limit 1522 bytes tagged, 1518 bytes untagged
// - A frame longer than the selected limit is marked dropped
// - Special-tag frames from CPU port to ports 1-4 skip the tagged limit
// - Reserve bit set gives 48 high priority buffers per queue, else none
// - VLAN enable bit turns 802.1q on; software fills VLAN table first
// - IGMP snoop bit sends every IGMP frame that is not dropped to the switch MII port
// - Direct mode: port 5 frames follow preamble routing, skipping lookup
// - Pre-tag bit marks frames to the MII port with their source port
// - Two-bit scheme selects strict priority or ratios 10/1, 5/1, 2/1
// - Tag mask bit uses low five VID bits as destination port mask
// - Mirror match set: mirror only when source and destination both match
// - Mirror match clear: mirror when source or destination matches
`timescale 1ns/1ps
module fpc_top #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Strap
  input wire logic size_limit_strap_pin_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Frame descriptor in
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [fpc_pkg::FPC_LEN_W-1:0] in_len_in,
  input wire logic in_tagged_in,
  input wire logic in_special_tag_protocol_id_in,
  input wire logic [2:0] in_src_port_in,
  input wire logic [4:0] in_lookup_mask_in,
  input wire logic [11:0] in_vid_in,
  input wire logic in_igmp_in,
  input wire logic [4:0] in_route_mask_in,
  input wire logic in_hi_prio_in,
  // Mirror configuration
  input wire logic [4:0] mirror_rx_mask_in,
  input wire logic [4:0] mirror_tx_mask_in,
  // Decision out
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [4:0] out_dest_mask_out,
  output logic out_drop_out,
  output logic out_mirror_out,
  output logic out_pretag_out,
  output logic [2:0] out_src_port_out,
  output logic out_hi_prio_out,
  // Global status
  output logic vlan_enable_out,
  output logic [5:0] reserved_buffers_out,
  // Egress scheduling
  input wire logic sched_hi_req_in,
  input wire logic sched_lo_req_in,
  output logic grant_hi_out,
  output logic grant_lo_out
);
  import fpc_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("fpc_top: FIFO_DEPTH too small");
  end

  // ----------------------------------------
  // Strap synchroniser and capture
  // ----------------------------------------
  logic strap_s1;
  logic strap_s2;
  logic [1:0] strap_cnt;
  wire strap_load = (strap_cnt == FPC_STRAP_WAIT);
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_cnt <= 2'h0;
    end else begin
      strap_s1 <= size_limit_strap_pin_in;
      strap_s2 <= strap_s1;
      strap_cnt <= (strap_cnt == FPC_STRAP_DONE) ? strap_cnt : strap_cnt + 2'h1;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic size_chk_dis;
  logic buf_reserve;
  logic [7:0] vlan_fwd;
  wire sel_size = (reg_addr_in == FPC_SIZE_BUF_OFS);
  wire sel_vlan = (reg_addr_in == FPC_VLAN_FWD_OFS);
  wire wr_size = reg_wr_in & sel_size;
  wire wr_vlan = reg_wr_in & sel_vlan;
  wire [7:0] size_rd = {6'h00, size_chk_dis, buf_reserve};
  wire [7:0] rd_mux = sel_size ? size_rd : sel_vlan ? vlan_fwd : FPC_UNMAPPED_VAL;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      size_chk_dis <= FPC_SIZE_BUF_RST[FPC_SIZE_CHK_DIS_BIT];
      buf_reserve <= FPC_SIZE_BUF_RST[FPC_BUF_RESERVE_BIT];
      vlan_fwd <= FPC_VLAN_FWD_RST;
      reg_rdata_out <= 8'h00;
    end else begin
      if (strap_load) begin
        size_chk_dis <= strap_s2;
      end else if (wr_size) begin
        size_chk_dis <= reg_wdata_in[FPC_SIZE_CHK_DIS_BIT];
      end
      if (wr_size) begin
        buf_reserve <= reg_wdata_in[FPC_BUF_RESERVE_BIT];
      end
      if (wr_vlan) begin
        vlan_fwd <= reg_wdata_in;
      end
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire vlan_en = vlan_fwd[FPC_VLAN_EN_BIT];
  wire igmp_snoop = vlan_fwd[FPC_IGMP_BIT];
  wire direct_mode = vlan_fwd[FPC_DIRECT_BIT];
  wire pretag_en = vlan_fwd[FPC_PRETAG_BIT];
  wire tag_mask_en = vlan_fwd[FPC_TAG_MASK_BIT];
  wire mirror_and = vlan_fwd[FPC_MIRROR_AND_BIT];
  wire fpc_prio_t scheme = fpc_prio_t'(vlan_fwd[FPC_PRIO_MSB:FPC_PRIO_LSB]);

  // ----------------------------------------
  // Length check
  // ----------------------------------------
  wire cpu_special = in_special_tag_protocol_id_in & (in_src_port_in == FPC_MII_PORT);
  wire use_tagged = in_tagged_in & ~cpu_special;
  wire [FPC_LEN_W-1:0] max_len = size_chk_dis ? FPC_LEN_LONG :
                                 use_tagged ? FPC_LEN_TAGGED :
                                 cpu_special ? FPC_LEN_LONG : FPC_LEN_UNTAGGED;
  wire too_long = (in_len_in > max_len);

  // ----------------------------------------
  // Destination selection
  // ----------------------------------------
  wire from_mii = (in_src_port_in == FPC_MII_PORT);
  wire [4:0] vid_mask = in_vid_in[FPC_PORTS-1:0];
  wire [4:0] base_mask = (direct_mode && from_mii) ? in_route_mask_in :
                         tag_mask_en ? vid_mask : in_lookup_mask_in;
  wire [4:0] dest_mask = (igmp_snoop && in_igmp_in) ? (base_mask | FPC_MII_MASK) : base_mask;

  // ----------------------------------------
  // Mirror match
  // ----------------------------------------
  wire [4:0] src_onehot = (in_src_port_in >= 3'h1 && in_src_port_in <= FPC_MII_PORT) ?
                          5'(5'h01 << (in_src_port_in - 3'h1)) : 5'h00;
  wire src_match = |(src_onehot & mirror_rx_mask_in);
  wire dst_match = |(dest_mask & mirror_tx_mask_in);
  wire mirror_hit = mirror_and ? (src_match & dst_match) : (src_match | dst_match);

  // ----------------------------------------
  // Policy word and FIFO
  // ----------------------------------------
  fpc_word_t word_in;
  fpc_word_t word_head;
  fpc_word_t word_out;
  fpc_fifo_if #(.W(FPC_WORD_W)) q_if ();
  assign word_in.dest = too_long ? 5'h00 : dest_mask;
  assign word_in.drop = too_long;
  assign word_in.mirror = mirror_hit & ~too_long;
  assign word_in.pretag = pretag_en & dest_mask[FPC_PORTS-1] & ~too_long;
  assign word_in.src = in_src_port_in;
  assign word_in.hi = in_hi_prio_in;
  assign q_if.wdata = word_in;
  assign q_if.wvalid = in_valid_in;
  assign in_ready_out = q_if.wready;
  assign word_head = fpc_word_t'(q_if.rdata);
  wire take_head = q_if.rvalid & q_if.rready;
  assign q_if.rready = ~out_valid_out | out_ready_in;

  fpc_fifo #(.WIDTH(FPC_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .q(q_if.fifo)
  );

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      out_valid_out <= 1'b0;
      word_out <= '0;
    end else begin
      if (q_if.rready) begin
        out_valid_out <= q_if.rvalid;
      end
      if (take_head) begin
        word_out <= word_head;
      end
    end
  end
  assign out_dest_mask_out = word_out.dest;
  assign out_drop_out = word_out.drop;
  assign out_mirror_out = word_out.mirror;
  assign out_pretag_out = word_out.pretag;
  assign out_src_port_out = word_out.src;
  assign out_hi_prio_out = word_out.hi;

  // ----------------------------------------
  // Global status
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      vlan_enable_out <= 1'b0;
      reserved_buffers_out <= FPC_NO_BUFS;
    end else begin
      vlan_enable_out <= vlan_en;
      reserved_buffers_out <= buf_reserve ? FPC_RESERVE_BUFS : FPC_NO_BUFS;
    end
  end

  // ----------------------------------------
  // Egress scheduler
  // ----------------------------------------
  fpc_sched u_sched (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .scheme_in(scheme),
    .hi_req_in(sched_hi_req_in),
    .lo_req_in(sched_lo_req_in),
    .grant_hi_out(grant_hi_out),
    .grant_lo_out(grant_lo_out)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_long_ok;
    size_chk_dis && in_len_in <= FPC_LEN_LONG |-> !word_in.drop;
  endproperty
  a_long_ok: assert property (p_long_ok) else $error("frame within 1536 dropped");

  property p_tag_limit;
    !size_chk_dis && in_tagged_in && !cpu_special && in_len_in == FPC_LEN_TAGGED + 11'h001 |-> word_in.drop;
  endproperty
  a_tag_limit: assert property (p_tag_limit) else $error("tagged frame over 1522 kept");

  property p_untag_limit;
    !size_chk_dis && !in_tagged_in && !cpu_special |-> word_in.drop == (in_len_in > FPC_LEN_UNTAGGED);
  endproperty
  a_untag_limit: assert property (p_untag_limit) else $error("untagged limit wrong");

  property p_drop_out;
    out_valid_out && out_drop_out |-> out_dest_mask_out == 5'h00 && !out_mirror_out;
  endproperty
  a_drop_out: assert property (p_drop_out) else $error("dropped frame still forwarded");

  property p_special;
    cpu_special && in_tagged_in && !size_chk_dis && in_len_in <= FPC_LEN_LONG |-> !word_in.drop;
  endproperty
  a_special: assert property (p_special) else $error("special tag frame hit tagged limit");

  property p_strap;
    strap_load |=> size_chk_dis == $past(strap_s2) && strap_cnt == FPC_STRAP_DONE;
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_reserve;
    wr_size ##1 1'b1 |=> reserved_buffers_out == ($past(reg_wdata_in[FPC_BUF_RESERVE_BIT], 2) ? 6'h30 : 6'h00);
  endproperty
  a_reserve: assert property (p_reserve) else $error("reserve count wrong");

  property p_vlan;
    wr_vlan |=> ##1 vlan_enable_out == $past(reg_wdata_in[FPC_VLAN_EN_BIT], 2);
  endproperty
  a_vlan: assert property (p_vlan) else $error("vlan enable not applied");

  property p_igmp;
    igmp_snoop && in_igmp_in && !too_long |-> word_in.dest[4];
  endproperty
  a_igmp: assert property (p_igmp) else $error("igmp frame missed MII port");

  property p_direct;
    direct_mode && from_mii && !too_long && !(igmp_snoop && in_igmp_in) |-> word_in.dest == in_route_mask_in;
  endproperty
  a_direct: assert property (p_direct) else $error("direct route ignored");

  property p_pretag;
    out_valid_out && out_pretag_out |-> out_dest_mask_out[4] && !out_drop_out;
  endproperty
  a_pretag: assert property (p_pretag) else $error("pretag without MII destination");

  property p_strict;
    scheme == FPC_PRIO_STRICT && sched_hi_req_in |=> grant_hi_out && !grant_lo_out;
  endproperty
  a_strict: assert property (p_strict) else $error("strict priority violated");

  property p_tagmask;
    tag_mask_en && !(direct_mode && from_mii) && !in_igmp_in && !too_long |-> word_in.dest == in_vid_in[4:0];
  endproperty
  a_tagmask: assert property (p_tagmask) else $error("tag mask not applied");

  property p_mirror_and;
    mirror_and && !too_long |-> word_in.mirror == (src_match && dst_match);
  endproperty
  a_mirror_and: assert property (p_mirror_and) else $error("AND mirror wrong");

  property p_mirror_or;
    !mirror_and && !too_long && src_match |-> word_in.mirror;
  endproperty
  a_mirror_or: assert property (p_mirror_or) else $error("OR mirror missed source");

  property p_hold;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed while stalled");

endmodule : fpc_top

// >>> rtl/fpc_pkg.sv
// Purpose: Shared constants and types for the switch frame policy control block
// Assumes: Ports 1..5 map onto mask bits 0..4; port 5 is the switch MII port
// Notes: Register offsets are byte addresses on the management register port
package fpc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] FPC_SIZE_BUF_OFS = 8'h04;
  localparam logic [7:0] FPC_VLAN_FWD_OFS = 8'h05;
  localparam logic [7:0] FPC_SIZE_BUF_RST = 8'h00;
  localparam logic [7:0] FPC_VLAN_FWD_RST = 8'h00;
  localparam logic [7:0] FPC_UNMAPPED_VAL = 8'h00;
  localparam int FPC_BUF_RESERVE_BIT = 0;
  localparam int FPC_SIZE_CHK_DIS_BIT = 1;
  localparam int FPC_MIRROR_AND_BIT = 0;
  localparam int FPC_TAG_MASK_BIT = 1;
  localparam int FPC_PRIO_LSB = 2;
  localparam int FPC_PRIO_MSB = 3;
  localparam int FPC_PRETAG_BIT = 4;
  localparam int FPC_DIRECT_BIT = 5;
  localparam int FPC_IGMP_BIT = 6;
  localparam int FPC_VLAN_EN_BIT = 7;
  // ----------------------------------------
  // Frame limits and ports
  // ----------------------------------------
  localparam int FPC_LEN_W = 11;
  localparam logic [10:0] FPC_LEN_LONG = 11'h600;
  localparam logic [10:0] FPC_LEN_TAGGED = 11'h5F2;
  localparam logic [10:0] FPC_LEN_UNTAGGED = 11'h5EE;
  localparam logic [5:0] FPC_RESERVE_BUFS = 6'h30;
  localparam logic [5:0] FPC_NO_BUFS = 6'h00;
  localparam int FPC_PORTS = 5;
  localparam logic [2:0] FPC_MII_PORT = 3'h5;
  localparam logic [4:0] FPC_MII_MASK = 5'h10;
  localparam logic [1:0] FPC_STRAP_WAIT = 2'h2;
  localparam logic [1:0] FPC_STRAP_DONE = 2'h3;
  // ----------------------------------------
  // Scheduling ratios
  // ----------------------------------------
  localparam logic [3:0] FPC_RATIO_10 = 4'hA;
  localparam logic [3:0] FPC_RATIO_5 = 4'h5;
  localparam logic [3:0] FPC_RATIO_2 = 4'h2;
  typedef enum logic [1:0] {FPC_PRIO_STRICT, FPC_PRIO_10_1, FPC_PRIO_5_1, FPC_PRIO_2_1} fpc_prio_t;
  typedef struct packed {
    logic [4:0] dest;
    logic drop;
    logic mirror;
    logic pretag;
    logic [2:0] src;
    logic hi;
  } fpc_word_t;
  localparam int FPC_WORD_W = $bits(fpc_word_t);
endpackage : fpc_pkg

// >>> rtl/fpc_fifo_if.sv
// Purpose: Carrier between the policy top and its decision FIFO
// Assumes: One clock domain
// Notes: Width follows the policy word
`timescale 1ns/1ps
interface fpc_fifo_if #(parameter int W = 12);
  logic [W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [W-1:0] rdata;
  logic rvalid;
  logic rready;
  modport fifo (input wdata, wvalid, rready, output wready, rdata, rvalid);
  modport user (output wdata, wvalid, rready, input wready, rdata, rvalid);
endinterface : fpc_fifo_if

// >>> rtl/fpc_fifo.sv
// Purpose: Flop based FIFO for policy words
// Assumes: DEPTH a power of two, at least 2
// Notes: wready is registered; rdata is the head entry
`timescale 1ns/1ps
module fpc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Queue
  fpc_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  if (DEPTH < 2 || (2 ** AW) != DEPTH || $bits(q.wdata) != WIDTH) begin : g_chk
    $error("fpc_fifo: unsupported depth or width");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic ready;
  wire push = q.wvalid & ready;
  wire pop = q.rvalid & q.rready;
  wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign q.wready = ready;
  assign q.rvalid = (cnt != '0);
  assign q.rdata = mem[rp];
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      ready <= 1'b0;
    end else begin
      wp <= push ? wp + 1'b1 : wp;
      rp <= pop ? rp + 1'b1 : rp;
      cnt <= next_cnt;
      ready <= (next_cnt != FULL);
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wp] <= q.wdata;
    end
  end
endmodule : fpc_fifo

// >>> rtl/fpc_sched.sv
// Purpose: High/low egress grant scheduler
// Assumes: Requests are levels from the same clock
// Notes: Low queue is served once the high run reaches the ratio
`timescale 1ns/1ps
module fpc_sched (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire fpc_pkg::fpc_prio_t scheme_in,
  input wire logic hi_req_in,
  input wire logic lo_req_in,
  // Grants
  output logic grant_hi_out,
  output logic grant_lo_out
);
  import fpc_pkg::*;
  logic [3:0] run;
  wire [3:0] limit = (scheme_in == FPC_PRIO_10_1) ? FPC_RATIO_10 :
                     (scheme_in == FPC_PRIO_5_1) ? FPC_RATIO_5 : FPC_RATIO_2;
  wire strict = (scheme_in == FPC_PRIO_STRICT);
  wire take_hi = hi_req_in & (strict | ~lo_req_in | (run < limit));
  wire take_lo = lo_req_in & ~take_hi;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      run <= 4'h0;
      grant_hi_out <= 1'b0;
      grant_lo_out <= 1'b0;
    end else begin
      grant_hi_out <= take_hi;
      grant_lo_out <= take_lo;
      run <= take_lo ? 4'h0 : (take_hi && run != 4'hF) ? run + 4'h1 : run;
    end
  end
endmodule : fpc_sched

// >>> verification/fpc_mii_partner.sv
// Purpose: Consumer model for the decision stream on the switch MII side
// Assumes: Ready moves a fixed 10 ns after each rising edge
// Notes: Mode 0 prompt, mode 1 every other cycle, mode 2 stalled
`timescale 1ns/1ps
module fpc_mii_partner (
  // Clock
  input wire logic sys_clk_in,
  // Control
  input wire logic [1:0] mode_in,
  // Stream
  output logic out_ready_out
);
  logic phase = 1'b0;
  initial out_ready_out = 1'b0;
  always @(posedge sys_clk_in) begin
    phase <= #10 ~phase;
    out_ready_out <= #10 (mode_in == 2'h0) || (mode_in == 2'h1 && phase);
  end
endmodule : fpc_mii_partner

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the frame policy control block
// Assumes: Register port strobes last one cycle; inputs move 10 ns after the edge
// Notes: Expected decision words come from shadow copies of both registers
`timescale 1ns/1ps
module tb_top;
  import fpc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, strap = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r4 = 8'h00, r5 = 8'h00;
  logic iv = 1'b0, tag = 1'b0, spec = 1'b0, igmp = 1'b0, hi = 1'b0, shr = 1'b0, slr = 1'b0;
  logic [10:0] len = 11'h000;
  logic [2:0] src = 3'h1, osrc;
  logic [4:0] lk = 5'h00, rt = 5'h00, mrx = 5'h14, mtx = 5'h10, dest;
  logic [11:0] vid = 12'h000;
  logic [1:0] pmode = 2'h0;
  logic [63:0] fwd_modes = {8'h02, 8'h40, 8'h20, 8'h10, 8'h01, 8'h00, 8'h73, 8'h8C};
  logic ir, ov, ordy, drop, mir, pt, ohi, ven, gh, gl;
  logic [5:0] rbuf;
  fpc_word_t exp_q[$], got_q[$];
  int fail_count = 0, comparisons = 0, cycles = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  fpc_top #(.FIFO_DEPTH(8)) dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .size_limit_strap_pin_in(strap), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .in_valid_in(iv), .in_ready_out(ir), .in_len_in(len),
    .in_tagged_in(tag), .in_special_tag_protocol_id_in(spec), .in_src_port_in(src),
    .in_lookup_mask_in(lk), .in_vid_in(vid), .in_igmp_in(igmp), .in_route_mask_in(rt), .in_hi_prio_in(hi),
    .mirror_rx_mask_in(mrx), .mirror_tx_mask_in(mtx), .out_valid_out(ov), .out_ready_in(ordy),
    .out_dest_mask_out(dest), .out_drop_out(drop), .out_mirror_out(mir), .out_pretag_out(pt),
    .out_src_port_out(osrc), .out_hi_prio_out(ohi), .vlan_enable_out(ven), .reserved_buffers_out(rbuf),
    .sched_hi_req_in(shr), .sched_lo_req_in(slr), .grant_hi_out(gh), .grant_lo_out(gl));
  fpc_mii_partner partner (.sys_clk_in(sys_clk_in), .mode_in(pmode), .out_ready_out(ordy));
  always @(negedge sys_clk_in) begin
    if (ov === 1'b1 && ordy === 1'b1) got_q.push_back({dest, drop, mir, pt, osrc, ohi});
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_val(string what, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk_val
  task automatic chk_word(fpc_word_t e, fpc_word_t g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected decision word expected %0h seen %0h", e, g);
    end
  endtask : chk_word
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic rst_seq(logic s);
    strap = s;
    sys_rst_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    #10 sys_rst_in = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #10 r4 = {6'h00, s, 1'b0};
    r5 = 8'h00;
  endtask : rst_seq
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    if (a == 8'h04) r4 = d & 8'h03;
    if (a == 8'h05) r5 = d;
    @(posedge sys_clk_in);
    #10 wr = 1'b0;
    @(posedge sys_clk_in);
    #10;
  endtask : wr_reg
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    addr = a;
    rd = 1'b1;
    @(posedge sys_clk_in);
    #10 rd = 1'b0;
    chk_val("register read", 16'(e), 16'(rdata));
    @(posedge sys_clk_in);
    #10;
  endtask : rd_chk
  function automatic fpc_word_t exp_w(int l, logic t, logic s, logic [2:0] sp, logic [4:0] lm,
    logic [11:0] v, logic ig, logic [4:0] rm, logic h);
    fpc_word_t w;
    int lim;
    lim = r4[1] ? 1536 : (s && sp == 3'h5) ? 1536 : t ? 1522 : 1518;
    w.dest = (r5[5] && sp == 3'h5) ? rm : r5[1] ? v[4:0] : lm;
    if (r5[6] && ig) w.dest[4] = 1'b1;
    w.mirror = r5[0] ? (mrx[sp-1] && |(w.dest & mtx)) : (mrx[sp-1] || |(w.dest & mtx));
    w.pretag = r5[4] && w.dest[4];
    w.drop = l > lim;
    if (w.drop) {w.dest, w.mirror, w.pretag} = 7'h00;
    w.src = sp;
    w.hi = h;
    return w;
  endfunction : exp_w
  task automatic sd(int l, logic t, logic s, logic [2:0] sp, logic [4:0] lm, logic [11:0] v,
    logic ig, logic [4:0] rm, logic h);
    len = l[10:0];
    {tag, spec, src, lk, vid, igmp, rt, hi} = {t, s, sp, lm, v, ig, rm, h};
    iv = 1'b1;
    for (int n = 0; n < 200 && ir !== 1'b1; n++) @(posedge sys_clk_in) #10;
    @(posedge sys_clk_in);
    #10 exp_q.push_back(exp_w(l, t, s, sp, lm, v, ig, rm, h));
  endtask : sd
  task automatic drain();
    iv = 1'b0;
    for (int n = 0; n < 400 && got_q.size() < exp_q.size(); n++) @(posedge sys_clk_in) #10;
    chk_val("word count", 16'(exp_q.size()), 16'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) chk_word(exp_q.pop_front(), got_q.pop_front());
    exp_q.delete();
    got_q.delete();
  endtask : drain
  task automatic sched_chk(logic [1:0] sch, int n);
    int run, seen, lo;
    run = 0;
    seen = 0;
    lo = 0;
    wr_reg(8'h05, {4'h0, sch, 2'h0});
    shr = 1'b1;
    slr = 1'b1;
    repeat (60) begin
      @(negedge sys_clk_in);
      if (gh === 1'b1 && gl === 1'b1) chk_val("grant overlap", 16'h0000, 16'h0001);
      if (gh === 1'b1) run++;
      if (gl === 1'b1) begin
        lo++;
        if (seen == 1) chk_val("high grant run", 16'(n), 16'(run));
        seen = 1;
        run = 0;
      end
    end
    if (n == 0) chk_val("strict low grants", 16'h0000, 16'(lo));
    @(posedge sys_clk_in);
    #10 {shr, slr} = 2'h0;
  endtask : sched_chk
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_seq(1'b1);
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h06, 8'h00);
    chk_val("reserved buffers", 16'h0000, 16'(rbuf));
    sd(1536, 0, 0, 3'h1, 5'h03, 12'h000, 0, 5'h00, 0);
    sd(1537, 1, 0, 3'h2, 5'h03, 12'h000, 0, 5'h00, 1);
    drain();
    wr_reg(8'h04, 8'h00);
    sd(1522, 1, 0, 3'h1, 5'h06, 12'h000, 0, 5'h00, 0);
    sd(1523, 1, 0, 3'h1, 5'h06, 12'h000, 0, 5'h00, 0);
    sd(1518, 0, 0, 3'h4, 5'h06, 12'h000, 0, 5'h00, 1);
    sd(1519, 0, 0, 3'h4, 5'h06, 12'h000, 0, 5'h00, 1);
    sd(1536, 1, 1, 3'h5, 5'h0F, 12'h000, 0, 5'h00, 0);
    sd(1537, 1, 1, 3'h5, 5'h0F, 12'h000, 0, 5'h00, 0);
    sd(1523, 1, 1, 3'h2, 5'h0F, 12'h000, 0, 5'h00, 0);
    drain();
    $display("test size_limits done");
    wr_reg(8'h04, 8'hFF);
    rd_chk(8'h04, 8'h03);
    chk_val("reserved buffers", 16'h0030, 16'(rbuf));
    wr_reg(8'h04, 8'h00);
    chk_val("reserved buffers", 16'h0000, 16'(rbuf));
    wr_reg(8'h05, 8'h80);
    chk_val("vlan enable", 16'h0001, 16'(ven));
    rd_chk(8'h05, 8'h80);
    wr_reg(8'h06, 8'h5A);
    rd_chk(8'h06, 8'h00);
    $display("test registers done");
    pmode = 2'h1;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h05, fwd_modes[i*8 +: 8]);
      sd(64, 0, 0, 3'h5, 5'h01, 12'h0A6, 1, 5'h0C, 1);
      sd(64, 0, 0, 3'h2, 5'h10, 12'h019, 0, 5'h03, 0);
      sd(100, 0, 0, 3'h3, 5'h14, 12'h0F3, 1, 5'h00, 1);
      drain();
    end
    $display("test forwarding_modes done");
    wr_reg(8'h05, 8'h00);
    pmode = 2'h2;
    for (int i = 0; i < 9; i++) sd(64 + i, 0, 0, 3'h1, 5'(i), 12'h000, 0, 5'h00, 0);
    iv = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #10 chk_val("ready when full", 16'h0000, 16'(ir));
    pmode = 2'h1;
    drain();
    chk_val("ready when empty", 16'h0001, 16'(ir));
    $display("test buffering done");
    sched_chk(2'h0, 0);
    sched_chk(2'h1, 10);
    sched_chk(2'h2, 5);
    sched_chk(2'h3, 2);
    $display("test scheduling done");
    rst_seq(1'b0);
    rd_chk(8'h04, 8'h00);
    $display("test strap_low done");
    tally_and_finish();
  end
endmodule : tb_top
